// *** csb_unit.sv ***
// Execution of compare, bit-test skip and conditional relative branches.
// Assumes the fetch logic presents one decoded instruction per issue
// pulse and waits for done before issuing the next.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Compare immediate sets flags, one cycle
// - Skip when register bit is clear
// - Skip when register bit is set
// - Skip when I/O bit is clear
// - Skip when I/O bit is set
// - Branch when selected flag is set
// - Branch when selected flag is clear
// - Carry clear or same-higher branch on C=0
// - Signed greater-equal branch when N xor V=0
// - Signed less-than branch when N xor V=1
// - Half carry set branch when H=1
module csb_unit
    import csb_pkg::*;
(
    input  wire logic              mclk,      // Core clock, 25 MHz
    input  wire logic              rstn,      // Async reset, active low
    input  wire logic              issue,     // Instruction valid pulse
    input  wire csb_instr_t        instr,     // Decoded instruction
    input  wire logic [PC_W-1:0]   pc_in,     // Address of this instruction
    input  wire logic [DATA_W-1:0] flags_in,  // Current status flags
    output logic                   busy,      // Second or third cycle of a multi-cycle instruction
    output logic                   done,      // Final cycle of instruction
    output csb_result_t            result     // Next pc, flags, cycles
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} csb_state_t;

    csb_state_t  state;
    logic [1:0]  remain;
    csb_result_t next_result;

    wire logic [DATA_W-1:0] cmp_flags;
    wire logic              reg_bit;
    wire logic              io_bit;
    wire logic              sel_flag;
    wire logic              sign_lt;
    wire logic              is_skip;
    wire logic              is_branch;
    wire logic              cond;
    wire logic [PC_W-1:0]   offset_ext;
    wire logic [PC_W-1:0]   skip_step;
    wire logic [1:0]        cyc_need;

    csb_compare u_cmp (
        .a         (instr.reg_val),
        .b         (instr.imm),
        .flags_in  (flags_in),
        .flags_out (cmp_flags)
    );

    assign reg_bit  = instr.reg_val[instr.bit_sel];
    assign io_bit   = instr.io_val[instr.bit_sel];
    assign sel_flag = flags_in[instr.bit_sel];
    assign sign_lt  = flags_in[FLAG_N] ^ flags_in[FLAG_V];

    assign is_skip   = (instr.op inside {OP_SKIP_REG_BIT_CLEAR,
                        OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
                        OP_SKIP_IO_BIT_SET});
    assign is_branch = (instr.op inside {OP_BRANCH_FLAG_SET,
                        OP_BRANCH_FLAG_CLEAR, OP_BRANCH_CARRY_CLEAR,
                        OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_SIGNED_GE,
                        OP_BRANCH_SIGNED_LT, OP_BRANCH_HALF_CARRY_SET});

    assign cond =
        (instr.op == OP_SKIP_REG_BIT_CLEAR)    ? ~reg_bit :
        (instr.op == OP_SKIP_REG_BIT_SET)      ?  reg_bit :
        (instr.op == OP_SKIP_IO_BIT_CLEAR)     ? ~io_bit :
        (instr.op == OP_SKIP_IO_BIT_SET)       ?  io_bit :
        (instr.op == OP_BRANCH_FLAG_SET)       ?  sel_flag :
        (instr.op == OP_BRANCH_FLAG_CLEAR)     ? ~sel_flag :
        (instr.op == OP_BRANCH_CARRY_CLEAR)    ? ~flags_in[FLAG_C] :
        (instr.op == OP_BRANCH_SAME_OR_HIGHER) ? ~flags_in[FLAG_C] :
        (instr.op == OP_BRANCH_SIGNED_GE)      ? ~sign_lt :
        (instr.op == OP_BRANCH_SIGNED_LT)      ?  sign_lt :
        (instr.op == OP_BRANCH_HALF_CARRY_SET) ?  flags_in[FLAG_H] :
        1'b0;

    // Sign-extend the word displacement
    assign offset_ext = {{(PC_W-OFS_W){instr.offset[OFS_W-1]}},
                         instr.offset};
    assign skip_step  = instr.next_two ? PC_STEP_3 : PC_STEP_2;

    assign cyc_need = !cond             ? CYC_ONE :
                      (is_skip && instr.next_two) ? CYC_THREE :
                      CYC_TWO;

    always_comb begin
        next_result        = '0;
        next_result.pc     = pc_in + PC_STEP_1;
        next_result.flags  = flags_in;
        next_result.cycles = CYC_ONE;
        next_result.taken  = 1'b0;
        if (instr.op == OP_COMPARE_IMMEDIATE) begin
            next_result.flags = cmp_flags;
        end else if (is_skip || is_branch) begin
            next_result.cycles = cyc_need;
            next_result.taken  = cond;
            if (cond && is_skip) begin
                next_result.pc = pc_in + skip_step;
            end else if (cond) begin
                next_result.pc = pc_in + offset_ext + PC_STEP_1;
            end
        end
    end

    assign busy = (state == ST_WAIT);

    // Done fires when the last cycle of the instruction elapses
    assign done = ((state == ST_IDLE) && issue
                   && (next_result.cycles == CYC_ONE))
                || ((state == ST_WAIT) && (remain == CYC_ONE));

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state  <= ST_IDLE;
            remain <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (issue && (next_result.cycles != CYC_ONE)) begin
                        state  <= ST_WAIT;
                        remain <= next_result.cycles - CYC_ONE;
                    end
                end
                ST_WAIT: begin
                    remain <= remain - CYC_ONE;
                    if (remain == CYC_ONE) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result <= '{pc: PC_RESET, flags: FLAGS_RESET,
                        cycles: CYC_ONE, taken: 1'b0};
        end else if ((state == ST_IDLE) && issue) begin
            result <= next_result;
        end
    end
endmodule // csb_unit
`default_nettype wire

// *** csb_pkg.sv ***
// Constants and types for the conditional skip and branch unit.
// Assumes an 8-bit core with a word-addressed program counter.
package csb_pkg;
    localparam int PC_W      = 16;
    localparam int DATA_W    = 8;
    localparam int OFS_W     = 7;
    localparam int BIT_SEL_W = 3;

    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    // Cycle counts
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // Program counter steps and reset values
    localparam logic [PC_W-1:0] PC_STEP_1 = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_2 = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_3 = 16'h0003;
    localparam logic [PC_W-1:0] PC_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_COMPARE_IMMEDIATE,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR,
        OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_SAME_OR_HIGHER,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALF_CARRY_SET
    } csb_op_t;

    typedef struct packed {
        csb_op_t                op;        // Instruction class
        logic [DATA_W-1:0]      reg_val;   // Destination or tested register
        logic [DATA_W-1:0]      imm;       // Immediate constant
        logic [DATA_W-1:0]      io_val;    // Addressed I/O register value
        logic [BIT_SEL_W-1:0]   bit_sel;   // Bit or flag selector
        logic [OFS_W-1:0]       offset;    // Signed word displacement
        logic                   next_two;  // Following instruction is 2 words
    } csb_instr_t;

    typedef struct packed {
        logic [PC_W-1:0]   pc;
        logic [DATA_W-1:0] flags;
        logic [1:0]        cycles;
        logic              taken;
    } csb_result_t;
endpackage

// *** csb_compare.sv ***
// Subtractor producing compare flags for register minus immediate.
// Pure combinational; flag bits the compare does not write pass through from flags_in.
`timescale 1ns/100ps
`default_nettype none
module csb_compare
    import csb_pkg::*;
(
    input  wire logic [DATA_W-1:0] a,       // Destination register
    input  wire logic [DATA_W-1:0] b,       // Constant operand
    input  wire logic [DATA_W-1:0] flags_in, // Current flags
    output logic      [DATA_W-1:0] flags_out // Flags after compare
);
    wire logic [DATA_W-1:0] diff;
    wire logic [DATA_W-1:0] borrow_v;
    wire logic              f_n;
    wire logic              f_v;

    assign diff     = a - b;
    // Borrow out of each bit position
    assign borrow_v = (~a & b) | (b & diff) | (diff & ~a);
    assign f_n      = diff[DATA_W-1];
    assign f_v      = (a[DATA_W-1] & ~b[DATA_W-1] & ~diff[DATA_W-1])
                    | (~a[DATA_W-1] & b[DATA_W-1] & diff[DATA_W-1]);

    always_comb begin
        flags_out         = flags_in;
        flags_out[FLAG_Z] = (diff == '0);
        flags_out[FLAG_N] = f_n;
        flags_out[FLAG_V] = f_v;
        flags_out[FLAG_S] = f_n ^ f_v;
        flags_out[FLAG_C] = borrow_v[DATA_W-1];
        flags_out[FLAG_H] = borrow_v[3];
    end
endmodule // csb_compare
`default_nettype wire

// *** csb_unit_properties.sv ***
// Port-level checker for csb_unit.
// Bound to the unit from the testbench; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module csb_unit_properties
    import csb_pkg::*;
(
    input wire logic              mclk,     // Core clock
    input wire logic              rstn,     // Reset, active low
    input wire logic              issue,    // Issue pulse
    input wire csb_instr_t        instr,    // Instruction
    input wire logic [PC_W-1:0]   pc_in,    // Instruction address
    input wire logic [DATA_W-1:0] flags_in, // Flags in
    input wire logic              busy,     // Extra cycles running
    input wire logic              done,     // Final cycle
    input wire csb_result_t       result    // Registered result
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic            go, br, nv, eq;
    logic [PC_W-1:0] tgt, skp;
    logic [PC_W-1:0] ofs;
    assign go  = issue & ~busy;
    assign br  = go && instr.op >= OP_BRANCH_FLAG_SET;
    assign nv  = flags_in[FLAG_N] ^ flags_in[FLAG_V];
    assign eq  = instr.reg_val == instr.imm;
    assign ofs = {{(PC_W-OFS_W){instr.offset[OFS_W-1]}}, instr.offset};
    assign tgt = pc_in + ofs + PC_STEP_1;
    assign skp = pc_in + (instr.next_two ? PC_STEP_3 : PC_STEP_2);
    one_cycle_a: assert property (go && done |=> result.cycles == CYC_ONE)
        else $error("one cycle op count wrong");
    two_cycle_a: assert property ($rose(busy) && result.cycles == CYC_TWO |-> done ##1 !busy)
        else $error("two cycle op timing wrong");
    three_cycle_a: assert property ($rose(busy) && result.cycles == CYC_THREE |-> !done ##1 busy && done ##1 !busy)
        else $error("three cycle op timing wrong");
    branch_target_a: assert property (br |=> result.pc == (result.taken ? $past(tgt) : $past(pc_in) + PC_STEP_1))
        else $error("branch target wrong");
    branch_flags_a: assert property (br |=> result.flags == $past(flags_in))
        else $error("branch changed flags");
    signed_lt_a: assert property (go && instr.op == OP_BRANCH_SIGNED_LT |=> result.taken == $past(nv))
        else $error("signed less branch wrong");
    carry_clear_a: assert property (go && instr.op == OP_BRANCH_CARRY_CLEAR |=> result.taken != $past(flags_in[FLAG_C]))
        else $error("carry clear branch wrong");
    cmp_zero_a: assert property (go && instr.op == OP_COMPARE_IMMEDIATE |=> result.flags[FLAG_Z] == $past(eq))
        else $error("compare zero flag wrong");
    skip_pc_a: assert property (go && instr.op == OP_SKIP_REG_BIT_SET && instr.reg_val[instr.bit_sel] |=> result.pc == $past(skp))
        else $error("skip target wrong");
    signed_ge_a: assert property (
        go && instr.op == OP_BRANCH_SIGNED_GE
        |=> result.taken != $past(nv))
        else $error("signed greater branch wrong");
    half_carry_a: assert property (
        go && instr.op == OP_BRANCH_HALF_CARRY_SET
        |=> result.taken == $past(flags_in[FLAG_H]))
        else $error("half carry branch wrong");
    io_clear_skip_a: assert property (
        go && instr.op == OP_SKIP_IO_BIT_CLEAR
        |=> result.taken == !$past(instr.io_val[instr.bit_sel]))
        else $error("io clear skip wrong");
endmodule // csb_unit_properties
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for csb_unit: compare, skips and branches.
// Binds csb_unit_properties to the unit.
`timescale 1ns/100ps
`default_nettype none
module testbench import csb_pkg::*;;
    logic            mclk, rstn, issue, busy, done;
    csb_instr_t      ins;
    logic [PC_W-1:0] pc;
    logic [7:0]      fl;
    csb_result_t     res;
    int              n_mismatch, tests_run;
    csb_unit csb_unit_i (.mclk(mclk), .rstn(rstn), .issue(issue), .instr(ins),
        .pc_in(pc), .flags_in(fl), .busy(busy), .done(done), .result(res));
    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    // Issue one op and follow it to done, bounded
    task automatic run(input logic [15:0] p, input logic [7:0] f,
                       input logic [15:0] epc, input logic [1:0] ec,
                       input logic [7:0] ef);
        int   k;
        logic d;
        @(negedge mclk);
        pc = p;
        fl = f;
        issue = 1;
        #1 d = done;
        k = 1;
        @(negedge mclk);
        issue = 0;
        #1;
        while (!d && k < 5) begin
            k++;
            d = done;
            if (!d) begin
                @(negedge mclk);
                #1;
            end
        end
        if (k == 5) begin
            cmp(0, 1, "timeout");
            report_and_stop();
        end
        cmp(res.pc, epc, "pc");
        cmp({k[1:0], res.cycles}, {ec, ec}, "cycles");
        cmp(res.flags, ef, "flags");
    endtask
    task automatic t_compare();
        ins = '{OP_COMPARE_IMMEDIATE, 8'h10, 8'h20, 8'h00, 3'h0, 7'h00, 1'b0};
        run(16'h0100, 8'hc0, 16'h0101, CYC_ONE, 8'hd5);
        ins = '{OP_COMPARE_IMMEDIATE, 8'h42, 8'h42, 8'h00, 3'h0, 7'h00, 1'b0};
        run(16'h0100, 8'h3f, 16'h0101, CYC_ONE, 8'h02);
        ins = '{OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0};
        run(16'h0100, 8'h00, 16'h0101, CYC_ONE, 8'h38);
        cmp(res.taken, 1'b0, "compare taken");
        ins = '{OP_NONE, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 1'b1};
        run(16'h0100, 8'h3f, 16'h0101, CYC_ONE, 8'h3f);
        cmp(res.taken, 1'b0, "idle op taken");
    endtask
    task automatic t_skip();
        logic       s;
        logic [7:0] v;
        for (int i = 2; i < 6; i++)
            for (int j = 0; j < 4; j++) begin
                v = 8'h08 ^ {8{j[0]}};
                ins = '{csb_op_t'(i), i < 4 ? v : ~v, 8'h00, i < 4 ? ~v : v,
                        3'h3, 7'h00, j[1]};
                s = v[3] == i[0];
                run(16'h0300, 8'h5a, s ? (j[1] ? 16'h0303 : 16'h0302) : 16'h0301,
                    s ? (j[1] ? CYC_THREE : CYC_TWO) : CYC_ONE, 8'h5a);
                cmp(res.taken, s, "skip taken");
            end
    endtask
    task automatic t_branch();
        logic       t;
        logic [7:0] f;
        logic [7:0] pat [8] = '{8'h01, 8'h00, 8'h04, 8'h0c,
                                8'h08, 8'h20, 8'hdf, 8'h3f};
        for (int i = 6; i < 13; i++)
            for (int j = 0; j < 16; j++) begin
                f = pat[j[2:0]];
                ins = '{csb_op_t'(i), 8'h00, 8'h00, 8'h00, j[2:0],
                        j[3] ? 7'h7d : 7'h05, 1'b0};
                case (csb_op_t'(i))
                    OP_BRANCH_FLAG_SET:       t = f[j[2:0]];
                    OP_BRANCH_FLAG_CLEAR:     t = !f[j[2:0]];
                    OP_BRANCH_SIGNED_GE:      t = !(f[FLAG_N] ^ f[FLAG_V]);
                    OP_BRANCH_SIGNED_LT:      t = f[FLAG_N] ^ f[FLAG_V];
                    OP_BRANCH_HALF_CARRY_SET: t = f[FLAG_H];
                    default:                  t = !f[FLAG_C];
                endcase
                run(16'h0200, f, t ? (j[3] ? 16'h01fe : 16'h0206) : 16'h0201,
                    t ? CYC_TWO : CYC_ONE, f);
                cmp(res.taken, t, "taken");
            end
    endtask
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        rstn = 0;
        issue = 0;
        ins = '0;
        pc = '0;
        fl = '0;
        repeat (6) @(posedge mclk);
        #1 cmp({busy, res}, {1'b0, PC_RESET, FLAGS_RESET, CYC_ONE, 1'b0}, "reset");
        @(negedge mclk);
        rstn = 1;
        t_compare();
        t_skip();
        t_branch();
        report_and_stop();
    end
endmodule // testbench
bind csb_unit csb_unit_properties csb_unit_properties_i (.mclk(mclk),
    .rstn(rstn), .issue(issue), .instr(instr), .pc_in(pc_in),
    .flags_in(flags_in), .busy(busy), .done(done), .result(result));
`default_nettype wire
